// ===== design/motor_logic.sv
// Bridge merging, sleep sequencing and stepper command decode of the motor driver.
`timescale 1ns/1ns
`include "motor_logic_regs.svh"
module motor_logic #(
    parameter int WORD_W = `WORD_W
) (
    input  wire logic                          CLK,
    input  wire logic                          SRST,
    input  wire logic                          DEVICE_RESET_N,
    input  wire logic                          SLEEP_N,
    input  wire logic                          LATCH_STROBE_FIRST,
    input  wire logic                          SERIAL_CLOCK_FIRST,
    input  wire logic                          SERIAL_DIN_FIRST,
    input  wire logic                          LATCH_STROBE_SECOND,
    input  wire logic                          SERIAL_CLOCK_SECOND,
    input  wire logic                          SERIAL_DIN_SECOND,
    input  wire logic                          BRIDGE_B_ON_INPUT,
    input  wire logic                          BRIDGE_B_DIRECTION_INPUT,
    input  wire logic                          BRIDGE_D_ON_INPUT,
    input  wire logic                          BRIDGE_D_DIRECTION_INPUT,
    output motor_logic_pkg::bridge_drive_t     BRIDGE_DRIVE,
    output motor_logic_pkg::stepper_cmd_t      STEPPER_FIRST,
    output motor_logic_pkg::stepper_cmd_t      STEPPER_SECOND,
    output logic                               STEPPER_MODE,
    output logic [2:0]                         MOTOR_SELECT_FIELD,
    output motor_logic_pkg::setup_misc_t       SETUP_MISC,
    output logic [WORD_W-1:0]                  EXTENDED_WORD,
    output logic                               OPERATING
);
    // Pin roles by mode.
    // Asleep, the first port writes the setup word when its data line is low at
    // the strobe rise, and the extended word when it is high; the second port
    // is ignored.
    // Awake with select 000, both ports feed their own stepper command register.
    // Awake with any other select, the ports are off and their pins become
    // bridge on and direction inputs.
    //
    // Latency: a pin passes two synchroniser stages before any logic reads it.
    // A strobe rise reaches the command outputs four cycles after the pin moves
    // and the setup outputs likewise; bridge pins reach the drive in three.
    //
    // Limitation: each serial clock level must last at least two cycles, or a
    // fall can be lost between synchroniser samples. The trade is a slow link
    // for a design with no second clock domain.
    // Words are taken whole: a strobe rise after fewer than sixteen falls is
    // dropped, so a host that loses sync cannot leave half a command behind.
    //
    // Shared pins: in DC modes the first port pins carry bridge A control and the second port pins bridge C.
    // Strobe pins double as bridge on inputs, clock pins as direction inputs.
    logic [1:0]        rst_s_r;
    logic [1:0]        sleep_s_r;
    logic [1:0]        b_on_s_r;
    logic [1:0]        b_dir_s_r;
    logic [1:0]        d_on_s_r;
    logic [1:0]        d_dir_s_r;
    logic [1:0]        a_on_s_r;
    logic [1:0]        a_dir_s_r;
    logic [1:0]        c_on_s_r;
    logic [1:0]        c_dir_s_r;
    logic              hold;
    logic              awake;
    logic              is_stepper;
    logic [WORD_W-1:0] setup_r;
    logic [WORD_W-1:0] ext_r;
    logic [WORD_W-1:0] cmd_first_r;
    logic [WORD_W-1:0] cmd_second_r;
    logic [WORD_W-1:0] word_first;
    logic [WORD_W-1:0] word_second;
    logic              latch_first;
    logic              latch_second;
    logic              latch_din_first;
    logic              port_first_active;
    logic              port_second_active;
    motor_logic_pkg::bridge_drive_t drive_nxt;
    motor_logic_pkg::bridge_drive_t drive_r;

    initial begin
        if (WORD_W != 16) $error("motor_logic supports 16-bit words only");
    end

    // Pin synchronisers; every pin is asynchronous to CLK.
    always_ff @(posedge CLK) begin
        rst_s_r   <= {rst_s_r[0], DEVICE_RESET_N};
        sleep_s_r <= {sleep_s_r[0], SLEEP_N};
        b_on_s_r  <= {b_on_s_r[0], BRIDGE_B_ON_INPUT};
        b_dir_s_r <= {b_dir_s_r[0], BRIDGE_B_DIRECTION_INPUT};
        d_on_s_r  <= {d_on_s_r[0], BRIDGE_D_ON_INPUT};
        d_dir_s_r <= {d_dir_s_r[0], BRIDGE_D_DIRECTION_INPUT};
        a_on_s_r  <= {a_on_s_r[0], LATCH_STROBE_FIRST};
        a_dir_s_r <= {a_dir_s_r[0], SERIAL_CLOCK_FIRST};
        c_on_s_r  <= {c_on_s_r[0], LATCH_STROBE_SECOND};
        c_dir_s_r <= {c_dir_s_r[0], SERIAL_CLOCK_SECOND};
    end

    // Device held idle while the reset pin is low or the block is reset.
    assign hold       = SRST || !rst_s_r[1];
    assign awake      = !hold && sleep_s_r[1];
    assign is_stepper = (setup_r[`MS_MSB:`MS_LSB] == `MS_TWO_STEPPER);

    // Port routing: asleep only the first port writes setup; awake with select 000 both serve steppers.
    assign port_first_active  = !hold && (!sleep_s_r[1] || is_stepper);
    assign port_second_active = awake && is_stepper;

    serial_shifter #(
        .WIDTH (WORD_W)
    ) u_port_first (
        .clk         (CLK),
        .srst        (SRST),
        .active      (port_first_active),
        .sclk_pin    (SERIAL_CLOCK_FIRST),
        .din_pin     (SERIAL_DIN_FIRST),
        .strobe_pin  (LATCH_STROBE_FIRST),
        .word        (word_first),
        .latch_pulse (latch_first),
        .latch_din   (latch_din_first)
    );

    serial_shifter #(
        .WIDTH (WORD_W)
    ) u_port_second (
        .clk         (CLK),
        .srst        (SRST),
        .active      (port_second_active),
        .sclk_pin    (SERIAL_CLOCK_SECOND),
        .din_pin     (SERIAL_DIN_SECOND),
        .strobe_pin  (LATCH_STROBE_SECOND),
        .word        (word_second),
        .latch_pulse (latch_second),
        .latch_din   ()
    );

    // Setup and extended registers load only while asleep; the data level steers them.
    // Sleep does not clear them, otherwise the configured mode would be lost on wake.
    always_ff @(posedge CLK) begin
        if (hold) begin
            setup_r <= `SETUP_RESET;
            ext_r   <= `EXT_RESET;
        end else if (latch_first && !sleep_s_r[1]) begin
            if (!latch_din_first) begin
                setup_r <= word_first;
            end else begin
                ext_r <= word_first;
            end
        end
    end

    // First stepper command register; a word lands only on the strobe rise.
    always_ff @(posedge CLK) begin
        if (hold || !sleep_s_r[1]) begin
            cmd_first_r <= `CMD_RESET;
        end else if (latch_first && is_stepper) begin
            cmd_first_r <= word_first;
        end
    end

    // Second stepper command register, fed from its own port.
    always_ff @(posedge CLK) begin
        if (hold || !sleep_s_r[1]) begin
            cmd_second_r <= `CMD_RESET;
        end else if (latch_second) begin
            cmd_second_r <= word_second;
        end
    end

    // Bridge drive merge. Ignored inputs are dropped, not combined, so a stray
    // level on an absorbed pin can never fight the merged bridge.
    always_comb begin
        drive_nxt = '0;
        if (awake && !is_stepper) begin
            case (setup_r[`MS_MSB:`MS_LSB])
                `MS_TWO_LARGE: begin
                    drive_nxt.on        = {{2{c_on_s_r[1]}}, {2{a_on_s_r[1]}}};
                    drive_nxt.direction = {{2{c_dir_s_r[1]}}, {2{a_dir_s_r[1]}}};
                end
                `MS_ULTRA_LARGE: begin
                    drive_nxt.on        = {4{a_on_s_r[1]}};
                    drive_nxt.direction = {4{a_dir_s_r[1]}};
                end
                default: begin
                    drive_nxt.on        = {d_on_s_r[1], c_on_s_r[1], b_on_s_r[1], a_on_s_r[1]};
                    drive_nxt.direction = {d_dir_s_r[1], c_dir_s_r[1], b_dir_s_r[1], a_dir_s_r[1]};
                end
            endcase
        end
    end

    // Registered bridge drive; cleared while held or asleep.
    always_ff @(posedge CLK) begin
        if (hold) begin
            drive_r <= '0;
        end else begin
            drive_r <= drive_nxt;
        end
    end

    // Field decode of both stepper commands; one packet holds both windings.
    function automatic motor_logic_pkg::stepper_cmd_t decode(input logic [15:0] w);
        motor_logic_pkg::stepper_cmd_t c;
        c.first.direction  = w[`DIR_A_BIT];
        c.first.level      = w[`LVL_A_LSB +: 4];
        c.first.decay      = motor_logic_pkg::decay_t'(w[`DEC_A_LSB +: 2]);
        c.second.direction = w[`DIR_B_BIT];
        c.second.level     = w[`LVL_B_LSB +: 4];
        c.second.decay     = motor_logic_pkg::decay_t'(w[`DEC_B_LSB +: 2]);
        c.torque           = motor_logic_pkg::torque_t'(w[`TORQUE_LSB +: 2]);
        return c;
    endfunction

    // First decoded command; it trails its command register by one cycle.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            STEPPER_FIRST <= '0;
        end else begin
            STEPPER_FIRST <= decode(cmd_first_r);
        end
    end

    // Second decoded command, fed from the second port's register.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            STEPPER_SECOND <= '0;
        end else begin
            STEPPER_SECOND <= decode(cmd_second_r);
        end
    end

    // The setup timing and gain fields pass through in every mode.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            SETUP_MISC <= '0;
        end else begin
            SETUP_MISC <= {setup_r[`OSC_LSB +: 2], setup_r[`GAIN_CD_BIT], setup_r[`GAIN_AB_BIT],
                           setup_r[`TBLNK_CD_LSB +: 2], setup_r[`TBLNK_AB_LSB +: 2]};
        end
    end

    // Motor select as last written while asleep.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            MOTOR_SELECT_FIELD <= 3'h0;
        end else begin
            MOTOR_SELECT_FIELD <= setup_r[`MS_MSB:`MS_LSB];
        end
    end

    // Extended word, kept only so the host side can observe it.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            EXTENDED_WORD <= '0;
        end else begin
            EXTENDED_WORD <= ext_r;
        end
    end

    // Stepper mode flag: awake with select 000.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            STEPPER_MODE <= 1'b0;
        end else begin
            STEPPER_MODE <= awake && is_stepper;
        end
    end

    // Operating flag: reset pin released and sleep pin high.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            OPERATING <= 1'b0;
        end else begin
            OPERATING <= awake;
        end
    end

    assign BRIDGE_DRIVE = drive_r;
endmodule

// ===== design/motor_logic_regs.svh
// Register layout, field positions, mode codes and timing counts of the motor logic.
`ifndef MOTOR_LOGIC_REGS_SVH
`define MOTOR_LOGIC_REGS_SVH
`define WORD_W            16
`define CMD_RESET         16'h0000
`define SETUP_RESET       16'h0000
`define EXT_RESET         16'h0000
`define MS_LSB            0
`define MS_MSB            2
`define MS_TWO_STEPPER    3'h0
`define MS_TWO_LARGE      3'h4
`define MS_ULTRA_LARGE    3'h7
`define TBLNK_AB_LSB      3
`define TBLNK_CD_LSB      5
`define GAIN_AB_BIT       10
`define GAIN_CD_BIT       11
`define OSC_LSB           14
`define DIR_A_BIT         15
`define LVL_A_LSB         11
`define DEC_A_LSB         9
`define DIR_B_BIT         8
`define LVL_B_LSB         4
`define DEC_B_LSB         2
`define TORQUE_LSB        0
`define MIN_SHIFT_EDGES   5'h10
`endif

// ===== design/motor_logic_pkg.sv
// Types shared by the motor logic files.
package motor_logic_pkg;
    typedef enum logic [1:0] {
        DECAY_12P5,
        DECAY_37P5,
        DECAY_75,
        DECAY_FAST
    } decay_t;
    typedef enum logic [1:0] {
        TORQUE_50,
        TORQUE_70,
        TORQUE_85,
        TORQUE_100
    } torque_t;
    // Decoded drive of one winding.
    typedef struct packed {
        logic        direction;
        logic [3:0]  level;
        decay_t      decay;
    } winding_t;
    // Decoded stepper command for one bridge pair.
    typedef struct packed {
        winding_t    first;
        winding_t    second;
        torque_t     torque;
    } stepper_cmd_t;
    // Drive request to the four power bridges.
    typedef struct packed {
        logic [3:0]  on;
        logic [3:0]  direction;
    } bridge_drive_t;
    // Timing and gain settings of the setup register.
    typedef struct packed {
        logic [1:0]  osc_select;
        logic        gain_cd;
        logic        gain_ab;
        logic [1:0]  blank_cd;
        logic [1:0]  blank_ab;
    } setup_misc_t;
endpackage

// ===== design/serial_shifter.sv
// Serial receiver: samples data on falling serial clock and reports strobe rise.
`timescale 1ns/1ns
`include "motor_logic_regs.svh"
module serial_shifter #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             active,
    input  wire logic             sclk_pin,
    input  wire logic             din_pin,
    input  wire logic             strobe_pin,
    output logic [WIDTH-1:0]      word,
    output logic                  latch_pulse,
    output logic                  latch_din
);
    logic [2:0]       sclk_s_r;
    logic [2:0]       strobe_s_r;
    logic [1:0]       din_s_r;
    logic [WIDTH-1:0] shift_r;
    logic [4:0]       edges_r;

    initial begin
        if (WIDTH != 16) $error("serial_shifter supports 16-bit words only");
    end

    // Two-stage synchronisers; the third stage only feeds edge detection.
    always_ff @(posedge clk) begin
        sclk_s_r   <= {sclk_s_r[1:0], sclk_pin};
        strobe_s_r <= {strobe_s_r[1:0], strobe_pin};
        din_s_r    <= {din_s_r[0], din_pin};
    end

    // Shift on each falling serial clock edge while strobe is low; an accepted latch restarts the count.
    always_ff @(posedge clk) begin
        if (srst || !active) begin
            shift_r <= '0;
            edges_r <= 5'h00;
        end else if (sclk_s_r[2] && !sclk_s_r[1] && !strobe_s_r[1]) begin
            shift_r <= {shift_r[WIDTH-2:0], din_s_r[1]};
            if (edges_r != `MIN_SHIFT_EDGES) begin
                edges_r <= edges_r + 5'h01;
            end
        end else if (latch_pulse) begin
            edges_r <= 5'h00;
        end
    end

    // A latch counts only after a full word, so short bursts cannot corrupt state.
    assign latch_pulse = active && !srst && strobe_s_r[1] && !strobe_s_r[2]
                         && (edges_r == `MIN_SHIFT_EDGES);
    assign latch_din   = din_s_r[1];
    assign word        = shift_r;
endmodule

// ===== tb/motor_logic_chk.sv
// Port assertions for the motor logic, attached to every instance by bind.
`timescale 1ns/1ns
module motor_logic_chk (
    input wire logic                           CLK,
    input wire logic                           SRST,
    input wire logic                           DEVICE_RESET_N,
    input wire logic                           SLEEP_N,
    input wire logic                           LATCH_STROBE_FIRST,
    input wire logic                           LATCH_STROBE_SECOND,
    input wire motor_logic_pkg::bridge_drive_t BRIDGE_DRIVE,
    input wire motor_logic_pkg::stepper_cmd_t  STEPPER_FIRST,
    input wire motor_logic_pkg::stepper_cmd_t  STEPPER_SECOND,
    input wire logic                           STEPPER_MODE,
    input wire logic [2:0]                     MOTOR_SELECT_FIELD,
    input wire logic                           OPERATING
);
    logic [3:0] age1_r;
    logic [3:0] age2_r;
    logic       stb1_r;
    logic       stb2_r;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    // Cycles since each strobe pin rose; it saturates so a stale rise never looks fresh.
    always_ff @(posedge CLK) begin
        stb1_r <= LATCH_STROBE_FIRST;
        stb2_r <= LATCH_STROBE_SECOND;
        age1_r <= SRST ? 4'hF : (LATCH_STROBE_FIRST && !stb1_r) ? 4'h0 : age1_r + {3'h0, age1_r != 4'hF};
        age2_r <= SRST ? 4'hF : (LATCH_STROBE_SECOND && !stb2_r) ? 4'h0 : age2_r + {3'h0, age2_r != 4'hF};
    end
    chk_sleep_idles: assert property (!SLEEP_N [*5] |-> !OPERATING && BRIDGE_DRIVE == 8'h00)
        else $error("bridges active while asleep");
    chk_pin_reset_holds: assert property (!DEVICE_RESET_N [*5] |-> !OPERATING && MOTOR_SELECT_FIELD == 3'h0)
        else $error("device active while reset pin low");
    chk_sleep_clears_cmd: assert property (!SLEEP_N [*5] |-> STEPPER_FIRST == 16'h0000 && STEPPER_SECOND == 16'h0000)
        else $error("stepper commands kept while asleep");
    chk_pair_merge: assert property (OPERATING && MOTOR_SELECT_FIELD == 3'h4 |-> !(^BRIDGE_DRIVE.on[1:0]) &&
        !(^BRIDGE_DRIVE.on[3:2]) && !(^BRIDGE_DRIVE.direction[1:0]) && !(^BRIDGE_DRIVE.direction[3:2]))
        else $error("pair bridges disagree in two-large mode");
    chk_quad_merge: assert property (OPERATING && MOTOR_SELECT_FIELD == 3'h7 |->
        BRIDGE_DRIVE.on inside {4'h0, 4'hF} && BRIDGE_DRIVE.direction inside {4'h0, 4'hF})
        else $error("bridges disagree in ultra-large mode");
    chk_stepper_mode_sel: assert property (STEPPER_MODE |-> OPERATING && MOTOR_SELECT_FIELD == 3'h0)
        else $error("stepper mode outside select 000");
    chk_first_on_strobe: assert property ($changed(STEPPER_FIRST) && STEPPER_FIRST != 16'h0000 |-> age1_r <= 4'hA)
        else $error("first command changed without strobe");
    chk_second_on_strobe: assert property ($changed(STEPPER_SECOND) && STEPPER_SECOND != 16'h0000 |-> age2_r <= 4'hA)
        else $error("second command changed without strobe");
    chk_setup_on_strobe: assert property ($changed(MOTOR_SELECT_FIELD) && MOTOR_SELECT_FIELD != 3'h0 |->
        !SLEEP_N && age1_r <= 4'hA)
        else $error("motor select changed without sleep strobe");
    cov_pair: cover property (OPERATING && MOTOR_SELECT_FIELD == 3'h4 && BRIDGE_DRIVE.on != 4'h0);
    cov_quad: cover property (OPERATING && MOTOR_SELECT_FIELD == 3'h7 && BRIDGE_DRIVE.on != 4'h0);
    cov_step: cover property (STEPPER_MODE && STEPPER_SECOND != 16'h0000);
endmodule
bind motor_logic motor_logic_chk chk_i (.CLK(CLK), .SRST(SRST), .DEVICE_RESET_N(DEVICE_RESET_N), .SLEEP_N(SLEEP_N),
    .LATCH_STROBE_FIRST(LATCH_STROBE_FIRST), .LATCH_STROBE_SECOND(LATCH_STROBE_SECOND), .BRIDGE_DRIVE(BRIDGE_DRIVE),
    .STEPPER_FIRST(STEPPER_FIRST), .STEPPER_SECOND(STEPPER_SECOND), .STEPPER_MODE(STEPPER_MODE),
    .MOTOR_SELECT_FIELD(MOTOR_SELECT_FIELD), .OPERATING(OPERATING));

// ===== tb/host_model.sv
// Host controller model driving the control pins and both serial ports.
`timescale 1ns/1ns
module host_model (
    input  wire logic  clk,
    output logic       reset_n,
    output logic       sleep_n,
    output logic [1:0] stb,
    output logic [1:0] sclk,
    output logic [1:0] din,
    output logic [3:0] bd
);
    // Everything idle at time zero; the serial clock rests low outside frames.
    initial begin
        reset_n = 1'b0;
        sleep_n = 1'b0;
        stb = 2'h0;
        sclk = 2'h0;
        din = 2'h0;
        bd = 4'h0;
    end
    // Level changes of the reset and sleep pins.
    task automatic ctrl(input logic r, input logic s);
        @(posedge clk);
        reset_n <= r;
        sleep_n <= s;
    endtask
    // Wake, then keep the shared strobe pin still long enough to be safe.
    task automatic wake();
        ctrl(1'b1, 1'b1);
        repeat (12500) @(posedge clk);
    endtask
    // Shift the low n bits, most significant first; the device samples on each fall.
    task automatic shift(input int p, input logic [15:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            din[p] <= w[i];
            sclk[p] <= 1'b1;
            repeat (15) @(posedge clk);
            sclk[p] <= 1'b0;
            repeat (16) @(posedge clk);
        end
    endtask
    // Strobe with din choosing the target; afterwards din flips so a stale level is never trusted.
    task automatic latch(input int p, input logic sel);
        @(posedge clk);
        din[p] <= sel;
        repeat (4) @(posedge clk);
        stb[p] <= 1'b1;
        repeat (12) @(posedge clk);
        stb[p] <= 1'b0;
        din[p] <= ~sel;
    endtask
    // DC pins, v = {a_on, a_dir, b_on, b_dir, c_on, c_dir, d_on, d_dir}.
    task automatic dc(input logic [7:0] v);
        @(posedge clk);
        stb <= {v[3], v[7]};
        sclk <= {v[2], v[6]};
        bd <= {v[5:4], v[1:0]};
    endtask
endmodule

// ===== tb/motor_logic_tb.sv
// Self-checking bench for the motor logic with the host model on its pins.
`timescale 1ns/1ns
module motor_logic_tb;
    logic                           CLK;
    logic                           SRST;
    logic                           rst_n;
    logic                           slp_n;
    logic [1:0]                     stb;
    logic [1:0]                     sclk;
    logic [1:0]                     din;
    logic [3:0]                     bd;
    motor_logic_pkg::bridge_drive_t drive;
    motor_logic_pkg::stepper_cmd_t  step1;
    motor_logic_pkg::stepper_cmd_t  step2;
    motor_logic_pkg::setup_misc_t   misc;
    logic                           smode;
    logic [2:0]                     msel;
    logic [15:0]                    ext;
    logic                           oper;
    int                             num_errors;
    int                             compares;
    host_model host (.clk(CLK), .reset_n(rst_n), .sleep_n(slp_n), .stb(stb), .sclk(sclk), .din(din), .bd(bd));
    motor_logic uut (.CLK(CLK), .SRST(SRST), .DEVICE_RESET_N(rst_n), .SLEEP_N(slp_n),
        .LATCH_STROBE_FIRST(stb[0]), .SERIAL_CLOCK_FIRST(sclk[0]), .SERIAL_DIN_FIRST(din[0]),
        .LATCH_STROBE_SECOND(stb[1]), .SERIAL_CLOCK_SECOND(sclk[1]), .SERIAL_DIN_SECOND(din[1]),
        .BRIDGE_B_ON_INPUT(bd[3]), .BRIDGE_B_DIRECTION_INPUT(bd[2]), .BRIDGE_D_ON_INPUT(bd[1]),
        .BRIDGE_D_DIRECTION_INPUT(bd[0]), .BRIDGE_DRIVE(drive), .STEPPER_FIRST(step1), .STEPPER_SECOND(step2),
        .STEPPER_MODE(smode), .MOTOR_SELECT_FIELD(msel), .SETUP_MISC(misc), .EXTENDED_WORD(ext), .OPERATING(oper));
    // Free-running 250 MHz clock.
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    // Sample one time unit after the edge so that edge's register updates have landed.
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic test_done();
        $display("Compares %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // A setup message sent while the reset pin is low must leave everything idle.
    task automatic test_reset_pin();
        host.shift(0, 16'h8834, 16);
        host.latch(0, 1'b0);
        tick(10);
        check(16'(msel), 16'h0000, "select under pin reset");
        check(16'(misc), 16'h0000, "misc under pin reset");
        check(16'(step1), 16'h0000, "first command reset");
        $display("test_reset_pin done");
    endtask
    // Configure asleep, overwrite the extended word, wake and drive mismatched pin patterns.
    task automatic test_merge(input logic [2:0] ms, input logic [15:0] w, input logic [7:0] e1, input logic [7:0] e2);
        host.ctrl(1'b1, 1'b0);
        tick(8);
        check(16'(drive), 16'h0000, "drive asleep");
        host.shift(0, w, 16);
        host.latch(0, 1'b0);
        tick(10);
        check(16'(msel), 16'(ms), "motor select");
        check(16'(misc), {8'h00, w[15:14], w[11:10], w[6:3]}, "setup misc");
        host.shift(0, ~w, 16);
        host.latch(0, 1'b1);
        tick(10);
        check(ext, ~w, "extended word");
        check(16'(msel), 16'(ms), "select kept");
        host.wake();
        check(16'(oper), 16'h0001, "operating");
        host.dc(8'hC6);
        tick(8);
        check(16'(drive), 16'(e1), "drive pattern one");
        host.dc(8'h69);
        tick(8);
        check(16'(drive), 16'(e2), "drive pattern two");
        host.dc(8'h00);
        $display("test_merge done");
    endtask
    // Two steppers: every decay and torque code on both ports, a partial word, then sleep.
    task automatic test_stepper();
        logic [15:0] w;
        logic [15:0] w2;
        logic [15:0] prev;
        prev = 16'h0000;
        host.ctrl(1'b1, 1'b0);
        host.shift(0, 16'h0000, 16);
        host.latch(0, 1'b0);
        host.wake();
        check(16'(smode), 16'h0001, "stepper mode");
        for (int i = 0; i < 4; i++) begin
            w = {i[0], 4'(5 * i + 1), 2'(i), ~i[0], 4'hF, 2'(3 - i), 2'(i)};
            w2 = {~w[15:8], w[7:0]};
            host.shift(0, w, 16);
            tick(4);
            check(16'(step1), prev, "held before strobe");
            host.latch(0, 1'b0);
            tick(10);
            check(16'(step1), w, "first command");
            host.shift(1, w2, 16);
            host.latch(1, 1'b0);
            tick(10);
            check(16'(step2), w2, "second command");
            check(16'(step1), w, "first untouched");
            prev = w;
        end
        host.shift(0, 16'h0000, 8);
        host.latch(0, 1'b0);
        tick(10);
        check(16'(step1), w, "short word refused");
        host.ctrl(1'b1, 1'b0);
        tick(8);
        check(16'(step1), 16'h0000, "first cleared");
        check(16'(step2), 16'h0000, "second cleared");
        check(16'(oper), 16'h0000, "asleep");
        $display("test_stepper done");
    endtask
    // Main sequence: two cycles of reset, then the scenarios in order.
    initial begin
        SRST = 1'b1;
        num_errors = 0;
        compares = 0;
        repeat (2) @(posedge CLK);
        SRST <= 1'b0;
        tick(4);
        test_reset_pin();
        test_merge(3'h4, 16'h8834, 8'h3F, 8'hC3);
        test_merge(3'h7, 16'h4C4F, 8'hFF, 8'h0F);
        test_merge(3'h5, 16'h2CAD, 8'h95, 8'h69);
        test_stepper();
        test_done();
    end
endmodule
